// file: src/bkrc_pkg.sv
package bkrc_pkg;

    // Register offsets on the device register map
    localparam logic [8:0] BKRC_A_CONF_ADDR = 9'h0D1;
    localparam logic [8:0] BKRC_B_CONF_ADDR = 9'h0D2;
    localparam logic [8:0] BKRC_PHASE_ADDR = 9'h0D3;
    localparam logic [8:0] BKRC_A_CEIL_ADDR = 9'h0D5;
    localparam logic [8:0] BKRC_B_CEIL_ADDR = 9'h0D6;
    localparam logic [8:0] BKRC_A_SET1_ADDR = 9'h0D7;
    localparam logic [8:0] BKRC_A_SET2_ADDR = 9'h0D8;

    // Reset values: both ramps at rate code 4 (20 mV/us), mode from settings, 1.0 V targets
    localparam logic [7:0] BKRC_CONF_RST = 8'h90;
    localparam logic [7:0] BKRC_PHASE_RST = 8'h00;
    localparam logic [7:0] BKRC_SET_RST = 8'h46;

    // Field positions
    localparam int BKRC_DOWN_LSB = 5;
    localparam int BKRC_UP_LSB = 2;
    localparam int BKRC_MODE_LSB = 0;
    localparam int BKRC_SHED_B_BIT = 4;
    localparam int BKRC_SHED_A_BIT = 3;
    localparam int BKRC_PH_B_BIT = 2;
    localparam int BKRC_PH_A_LSB = 0;
    localparam int BKRC_AUTO_BIT = 7;

    // Codes
    localparam logic [2:0] BKRC_RATE_NONE = 3'h7;
    localparam logic [6:0] BKRC_CODE_FLOOR = 7'h00;
    localparam logic [1:0] BKRC_MODE_FROM_SET = 2'h0;
    localparam logic [1:0] BKRC_MODE_AUTO_1PH = 2'h1;
    localparam logic [1:0] BKRC_MODE_PWM = 2'h2;
    localparam logic [1:0] BKRC_PH_A_TWO = 2'h1;
    localparam logic [2:0] BKRC_ONE_PHASE = 3'h1;
    localparam logic [2:0] BKRC_TWO_PHASES = 3'h2;

    // Ramp timing: one code step is 10 mV; rates in units of 10 uV/us
    localparam int BKRC_STEP_UV = 10000;
    localparam int BKRC_CLK_NS = 5;
    localparam int BKRC_RATE_0 = 125;
    localparam int BKRC_RATE_1 = 250;
    localparam int BKRC_RATE_2 = 500;
    localparam int BKRC_RATE_3 = 1000;
    localparam int BKRC_RATE_4 = 2000;
    localparam int BKRC_RATE_5 = 3000;
    localparam int BKRC_RATE_6 = 4000;

    typedef logic [10:0] bkrc_cnt_t;

    // Cycles per 10 mV step, rounded up so a ramp is never faster than set
    function automatic bkrc_cnt_t bkrc_step_cycles(input logic [2:0] code);
        int rate;
        int den;
        unique case (code)
            3'h0: rate = BKRC_RATE_0;
            3'h1: rate = BKRC_RATE_1;
            3'h2: rate = BKRC_RATE_2;
            3'h3: rate = BKRC_RATE_3;
            3'h4: rate = BKRC_RATE_4;
            3'h5: rate = BKRC_RATE_5;
            default: rate = BKRC_RATE_6;
        endcase
        den = rate * 10 * BKRC_CLK_NS;
        return bkrc_cnt_t'((BKRC_STEP_UV * 1000 + den - 1) / den);
    endfunction

    typedef enum logic [1:0] {BKRC_PWM, BKRC_AUTO, BKRC_AUTO_1PH} bkrc_mode_e;

    typedef struct packed {
        logic on;
        logic [6:0] vcode;
        bkrc_mode_e mode;
        logic [2:0] phases;
        logic shed;
    } bkrc_rail_s;

endpackage

// file: src/bkrc_ramp.sv
`timescale 1ns/1ps
module bkrc_ramp
    import bkrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [6:0] target,
    input wire logic [2:0] up_rate,
    input wire logic [2:0] down_rate,
    output logic [6:0] vcode,
    output logic on
);

    typedef enum logic [1:0] {BKRC_R_OFF, BKRC_R_REG, BKRC_R_DOWN} bkrc_ramp_e;

    bkrc_ramp_e state;
    bkrc_cnt_t cnt;
    logic rising;
    logic moving;
    logic [2:0] rate_sel;
    logic tick;

    // Direction and pace of the current move
    always_comb begin
        rising = (state == BKRC_R_REG) && (vcode < target);
        moving = (state == BKRC_R_DOWN) ? (vcode != BKRC_CODE_FLOOR) :
                 (state == BKRC_R_REG) && (vcode != target);
        rate_sel = rising ? up_rate : down_rate;
        tick = moving && (cnt == '0);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pace counter; idles at the full step so a move starts one step late
    always_ff @(posedge clk) begin
        if (!rst_n || !moving || tick) begin
            cnt <= bkrc_step_cycles(rate_sel) - bkrc_cnt_t'(1);
        end else begin
            cnt <= cnt - bkrc_cnt_t'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rail state and output code
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= BKRC_R_OFF;
            vcode <= BKRC_CODE_FLOOR;
        end else begin
            unique case (state)
                BKRC_R_OFF: begin
                    if (en) begin
                        state <= BKRC_R_REG;
                        // Soft start from the floor unless disabled
                        vcode <= (up_rate == BKRC_RATE_NONE) ? target : BKRC_CODE_FLOOR;
                    end
                end
                BKRC_R_REG: begin
                    if (!en) begin
                        state <= (down_rate == BKRC_RATE_NONE) ? BKRC_R_OFF : BKRC_R_DOWN;
                        if (down_rate == BKRC_RATE_NONE) begin
                            vcode <= BKRC_CODE_FLOOR;
                        end
                    end else if (rising && up_rate == BKRC_RATE_NONE) begin
                        vcode <= target;
                    end else if (tick) begin
                        vcode <= rising ? vcode + 7'h01 : vcode - 7'h01;
                    end
                end
                BKRC_R_DOWN: begin
                    if (en) begin
                        state <= BKRC_R_REG;
                    end else if (vcode == BKRC_CODE_FLOOR) begin
                        state <= BKRC_R_OFF;
                    end else if (tick) begin
                        vcode <= vcode - 7'h01;
                    end
                end
            endcase
        end
    end

    assign on = (state != BKRC_R_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the ramp sequencing
    sequence s_step;
        $changed(vcode) && (state == BKRC_R_REG || state == BKRC_R_DOWN);
    endsequence

    // A paced step reloads the counter, so the code cannot move again on the next edge
    property p_step_spacing;
        @(posedge clk) disable iff (!rst_n)
        s_step |=> $stable(vcode) || $past(up_rate) == BKRC_RATE_NONE ||
            $past(down_rate) == BKRC_RATE_NONE;
    endproperty

    step_gap_a: assert property (p_step_spacing)
        else $error("ramp code moved on two edges in a row");

    no_ramp_up_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == BKRC_R_OFF && en && up_rate == BKRC_RATE_NONE) |=> vcode == $past(target))
        else $error("start-up with no soft start did not jump to target");

    soft_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == BKRC_R_OFF && en && up_rate != BKRC_RATE_NONE) |=> vcode == BKRC_CODE_FLOOR)
        else $error("soft start did not begin at the floor code");

    hard_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == BKRC_R_REG && !en && down_rate == BKRC_RATE_NONE) |=> !on)
        else $error("unramped power down left the rail on");

    step_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && state == BKRC_R_DOWN && !en) |=> cnt == bkrc_step_cycles($past(rate_sel)) - 1)
        else $error("ramp step pace reload wrong");

    one_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == BKRC_R_DOWN && $past(state) == BKRC_R_DOWN && $past(!en) && !$past(tick))
        |-> vcode == $past(vcode))
        else $error("ramp moved between pace ticks");

endmodule

// file: src/bkrc_core.sv
`timescale 1ns/1ps
module bkrc_core
    import bkrc_pkg::*;
#(
    parameter bit FOUR_PHASE_VARIANT = 1'b0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic test_mode,
    input wire logic [6:0] otp_a_ceiling,
    input wire logic [6:0] otp_b_ceiling,
    input wire logic rail_a_enable,
    input wire logic rail_b_enable,
    input wire logic rail_a_setting_select,
    input wire logic [6:0] rail_b_target_code,
    input wire logic rail_b_target_auto,
    output bkrc_rail_s rail_a_status,
    output bkrc_rail_s rail_b_status
);

    logic [7:0] rail_a_ramp_mode_config;
    logic [7:0] rail_b_ramp_mode_config;
    logic [7:0] phase_shedding_config;
    logic [6:0] rail_a_ceiling_code;
    logic [6:0] rail_b_ceiling_code;
    logic [7:0] rail_a_first_setting;
    logic [7:0] rail_a_second_setting;
    logic [6:0] rail_a_target;
    logic [6:0] rail_b_target;
    logic rail_a_sel_auto;
    logic [6:0] ramp_a_code;
    logic [6:0] ramp_b_code;
    logic ramp_a_on;
    logic ramp_b_on;
    bkrc_rail_s next_a_status;
    bkrc_rail_s next_b_status;
    logic [7:0] next_rdata;

    // Clamp a requested code to the rail ceiling
    function automatic logic [6:0] bkrc_clamp(input logic [6:0] req, input logic [6:0] ceil);
        return (req > ceil) ? ceil : req;
    endfunction

    // Effective operating mode from the mode field and the setting's auto bit
    function automatic bkrc_mode_e bkrc_mode(input logic [1:0] field, input logic sel_auto);
        unique case (field)
            BKRC_MODE_FROM_SET: return sel_auto ? BKRC_AUTO : BKRC_PWM;
            BKRC_MODE_AUTO_1PH: return BKRC_AUTO_1PH;
            BKRC_MODE_PWM: return BKRC_PWM;
            default: return BKRC_AUTO;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Software configuration registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rail_a_ramp_mode_config <= BKRC_CONF_RST;
            rail_b_ramp_mode_config <= BKRC_CONF_RST;
            phase_shedding_config <= BKRC_PHASE_RST;
            rail_a_first_setting <= BKRC_SET_RST;
            rail_a_second_setting <= BKRC_SET_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                BKRC_A_CONF_ADDR: rail_a_ramp_mode_config <= reg_wdata;
                BKRC_B_CONF_ADDR: rail_b_ramp_mode_config <= reg_wdata;
                BKRC_PHASE_ADDR: phase_shedding_config <= reg_wdata;
                BKRC_A_SET1_ADDR: rail_a_first_setting <= reg_wdata;
                BKRC_A_SET2_ADDR: rail_a_second_setting <= reg_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ceilings: loaded from OTP in reset, writable only in test mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rail_a_ceiling_code <= otp_a_ceiling;
            rail_b_ceiling_code <= otp_b_ceiling;
        end else if (reg_wr && test_mode) begin
            if (reg_addr == BKRC_A_CEIL_ADDR) begin
                rail_a_ceiling_code <= reg_wdata[6:0];
            end
            if (reg_addr == BKRC_B_CEIL_ADDR) begin
                rail_b_ceiling_code <= reg_wdata[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active targets after setting selection and ceiling clamp
    always_comb begin
        rail_a_sel_auto = rail_a_setting_select ? rail_a_second_setting[BKRC_AUTO_BIT] :
                          rail_a_first_setting[BKRC_AUTO_BIT];
        rail_a_target = bkrc_clamp(rail_a_setting_select ? rail_a_second_setting[6:0] :
                                   rail_a_first_setting[6:0], rail_a_ceiling_code);
        rail_b_target = bkrc_clamp(rail_b_target_code, rail_b_ceiling_code);
    end

    bkrc_ramp u_ramp_a (
        .clk(clk),
        .rst_n(rst_n),
        .en(rail_a_enable),
        .target(rail_a_target),
        .up_rate(rail_a_ramp_mode_config[BKRC_UP_LSB +: 3]),
        .down_rate(rail_a_ramp_mode_config[BKRC_DOWN_LSB +: 3]),
        .vcode(ramp_a_code),
        .on(ramp_a_on)
    );

    bkrc_ramp u_ramp_b (
        .clk(clk),
        .rst_n(rst_n),
        .en(rail_b_enable),
        .target(rail_b_target),
        .up_rate(rail_b_ramp_mode_config[BKRC_UP_LSB +: 3]),
        .down_rate(rail_b_ramp_mode_config[BKRC_DOWN_LSB +: 3]),
        .vcode(ramp_b_code),
        .on(ramp_b_on)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Rail status words; phase count is what PWM operation would use
    always_comb begin
        next_a_status.on = ramp_a_on;
        next_a_status.vcode = ramp_a_code;
        next_a_status.mode = bkrc_mode(rail_a_ramp_mode_config[BKRC_MODE_LSB +: 2],
                                       rail_a_sel_auto);
        next_a_status.shed = phase_shedding_config[BKRC_SHED_A_BIT];
        // Only the four-phase variant has the extra power stages
        if (!FOUR_PHASE_VARIANT &&
            phase_shedding_config[BKRC_PH_A_LSB +: 2] > BKRC_PH_A_TWO) begin
            next_a_status.phases = BKRC_TWO_PHASES;
        end else begin
            next_a_status.phases = {1'b0, phase_shedding_config[BKRC_PH_A_LSB +: 2]}
                                   + BKRC_ONE_PHASE;
        end
        next_b_status.on = ramp_b_on;
        next_b_status.vcode = ramp_b_code;
        next_b_status.mode = bkrc_mode(rail_b_ramp_mode_config[BKRC_MODE_LSB +: 2],
                                       rail_b_target_auto);
        next_b_status.shed = phase_shedding_config[BKRC_SHED_B_BIT];
        next_b_status.phases = phase_shedding_config[BKRC_PH_B_BIT] ? BKRC_TWO_PHASES :
                               BKRC_ONE_PHASE;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rail_a_status <= '0;
            rail_b_status <= '0;
        end else begin
            rail_a_status <= next_a_status;
            rail_b_status <= next_b_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-back; reserved bits and unmapped offsets read as zero
    always_comb begin
        unique case (reg_addr)
            BKRC_A_CONF_ADDR: next_rdata = rail_a_ramp_mode_config;
            BKRC_B_CONF_ADDR: next_rdata = rail_b_ramp_mode_config;
            BKRC_PHASE_ADDR: next_rdata = {3'h0, phase_shedding_config[4:0]};
            BKRC_A_CEIL_ADDR: next_rdata = {1'b0, rail_a_ceiling_code};
            BKRC_B_CEIL_ADDR: next_rdata = {1'b0, rail_b_ceiling_code};
            BKRC_A_SET1_ADDR: next_rdata = rail_a_first_setting;
            BKRC_A_SET2_ADDR: next_rdata = rail_a_second_setting;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
            reg_rvalid <= reg_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on configuration decoding
    sequence s_ceil_write;
        reg_wr && !test_mode && reg_addr == BKRC_A_CEIL_ADDR;
    endsequence

    ceil_protect_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_ceil_write |=> $stable(rail_a_ceiling_code))
        else $error("ceiling changed outside test mode");

    // Above a lowered ceiling the rail may only hold or fall, never climb further
    ceil_clamp_a: assert property (@(posedge clk) disable iff (!rst_n)
        rail_a_status.vcode > rail_a_ceiling_code
        |=> rail_a_status.vcode <= $past(rail_a_status.vcode))
        else $error("rail A climbed above its ceiling");

    target_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
        rail_a_target <= rail_a_ceiling_code && rail_b_target <= rail_b_ceiling_code)
        else $error("applied target above ceiling");

    phase_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
        !FOUR_PHASE_VARIANT |-> rail_a_status.phases <= BKRC_TWO_PHASES)
        else $error("rail A phases above two on this variant");

    pwm_force_a: assert property (@(posedge clk) disable iff (!rst_n)
        rail_a_ramp_mode_config[1:0] == BKRC_MODE_PWM |=> rail_a_status.mode == BKRC_PWM)
        else $error("forced PWM mode not reported");

    set_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rail_a_ramp_mode_config[1:0] == BKRC_MODE_FROM_SET && rail_a_setting_select)
        |=> rail_a_status.mode == ($past(rail_a_second_setting[7]) ? BKRC_AUTO : BKRC_PWM))
        else $error("second setting mode bit not applied");

    rb_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
        phase_shedding_config[BKRC_PH_B_BIT] |=> rail_b_status.phases == BKRC_TWO_PHASES)
        else $error("rail B phase count wrong");

    read_ceil_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == BKRC_B_CEIL_ADDR |=> reg_rvalid && reg_rdata[7] == 1'b0
        && reg_rdata[6:0] == $past(rail_b_ceiling_code))
        else $error("ceiling read-back wrong");

endmodule

// file: dv/bkrc_core_bench.sv
`timescale 1ns/1ps
module bkrc_core_bench;
    import bkrc_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, test_mode, rail_a_enable, rail_b_enable;
    logic rail_a_setting_select, rail_b_target_auto, reg_rvalid;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [6:0] otp_a_ceiling, otp_b_ceiling, rail_b_target_code;
    bkrc_rail_s rail_a_status, rail_b_status;
    int fails, checks_done, n;
    typedef struct packed {logic [8:0] a; logic [7:0] w; logic [7:0] r;} bkrc_row_s;
    typedef struct packed {logic [1:0] m; logic sel; bkrc_mode_e e;} bkrc_mrow_s;
    typedef struct packed {logic [7:0] v; logic [2:0] pa; logic sa; logic [2:0] pb; logic sb;} bkrc_prow_s;
    // Reset defaults, then write/readback rows; reserved bits and unmapped places read 0
    bkrc_row_s dflt[7] = '{'{9'h0D1, 8'h00, 8'h90}, '{9'h0D2, 8'h00, 8'h90},
        '{9'h0D3, 8'h00, 8'h00}, '{9'h0D5, 8'h00, 8'h50}, '{9'h0D6, 8'h00, 8'h7F},
        '{9'h0D7, 8'h00, 8'h46}, '{9'h0D8, 8'h00, 8'h46}};
    bkrc_row_s rows[9] = '{'{9'h0D1, 8'hAB, 8'hAB}, '{9'h0D2, 8'h55, 8'h55},
        '{9'h0D3, 8'hFF, 8'h1F}, '{9'h0D5, 8'h11, 8'h50}, '{9'h0D6, 8'h00, 8'h7F},
        '{9'h0D7, 8'hC5, 8'hC5}, '{9'h0D8, 8'h3A, 8'h3A}, '{9'h0D4, 8'hFF, 8'h00},
        '{9'h1FF, 8'hFF, 8'h00}};
    bkrc_mrow_s mrows[5] = '{'{2'h1, 1'b0, BKRC_AUTO_1PH}, '{2'h2, 1'b1, BKRC_PWM},
        '{2'h3, 1'b0, BKRC_AUTO}, '{2'h0, 1'b0, BKRC_PWM}, '{2'h0, 1'b1, BKRC_AUTO}};
    // Rail A above two phases is capped because the default build is not the four-phase one
    bkrc_prow_s prows[6] = '{'{8'h00, 3'h1, 1'b0, 3'h1, 1'b0}, '{8'h01, 3'h2, 1'b0, 3'h1, 1'b0},
        '{8'h02, 3'h2, 1'b0, 3'h1, 1'b0}, '{8'h03, 3'h2, 1'b0, 3'h1, 1'b0},
        '{8'h0C, 3'h1, 1'b1, 3'h2, 1'b0}, '{8'h14, 3'h1, 1'b0, 3'h2, 1'b1}};
    // Cycles per 10 mV step at 5 ns, from 1.25 up to 40 mV/us, the 30 mV/us rate rounded up
    int step_tab[7] = '{1600, 800, 400, 200, 100, 67, 50};

    bkrc_core #(.FOUR_PHASE_VARIANT(1'b0)) uut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .test_mode(test_mode), .otp_a_ceiling(otp_a_ceiling),
        .otp_b_ceiling(otp_b_ceiling), .rail_a_enable(rail_a_enable),
        .rail_b_enable(rail_b_enable), .rail_a_setting_select(rail_a_setting_select),
        .rail_b_target_code(rail_b_target_code), .rail_b_target_auto(rail_b_target_auto),
        .rail_a_status(rail_a_status), .rail_b_status(rail_b_status));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparisons, bus cycles and bounded waits
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_span(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            fails++;
            $display("BAD at %0t: %0d cycles, expected %0d to %0d", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read strobe for one cycle; data and valid stand only in the cycle after it
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
    endtask

    // Counts edges until a status field matches; a hang ends the run
    task automatic wait_st(input bit b, input bit by_code, input logic [6:0] v, input int bound);
        bkrc_rail_s s;
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit && n < bound) begin
            @(posedge clk);
            #1;
            n++;
            s = b ? rail_b_status : rail_a_status;
            hit = ((by_code ? s.vcode : {6'h00, s.on}) === v);
        end
        if (!hit) begin
            fails++;
            $display("BAD at %0t: status wait ran out", $time);
            complete_run();
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({7'h00, reg_rvalid}, 8'h00);
        chk(8'(rail_a_status), 8'h00);
        chk(8'(rail_b_status), 8'h00);
    endtask

    task automatic complete_run();
        $display("Checks made: %0d, mismatches: %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fails = 0;
        checks_done = 0;
        rst_n <= 1'b0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= 9'h000;
        reg_wdata <= 8'h00;
        test_mode <= 1'b0;
        otp_a_ceiling <= 7'h50;
        otp_b_ceiling <= 7'h7F;
        rail_a_enable <= 1'b0;
        rail_b_enable <= 1'b0;
        rail_a_setting_select <= 1'b0;
        rail_b_target_code <= 7'h10;
        rail_b_target_auto <= 1'b1;
        do_reset();
        foreach (dflt[i]) rd_chk(dflt[i].a, dflt[i].r);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd_chk(rows[i].a, rows[i].r);
        end
        $display("register table test done");
        // Every ramp code both ways: one 10 mV step up, then down to zero and off
        for (int c = 0; c < 7; c++) begin
            wr(BKRC_A_CONF_ADDR, {3'(c), 3'(c), 2'h2});
            wr(BKRC_A_SET1_ADDR, 8'h01);
            @(posedge clk);
            rail_a_enable <= 1'b1;
            wait_st(1'b0, 1'b1, 7'h01, 2000);
            chk_span(n, step_tab[c], step_tab[c] + 4);
            @(posedge clk);
            rail_a_enable <= 1'b0;
            wait_st(1'b0, 1'b0, 7'h00, 2000);
            chk_span(n, step_tab[c], step_tab[c] + 5);
        end
        $display("ramp rate test done");
        // Immediate start, ceiling clamp, setting switch and unramped switch-off
        wr(BKRC_A_CONF_ADDR, 8'hFE);
        wr(BKRC_A_SET1_ADDR, 8'h7F);
        wr(BKRC_A_SET2_ADDR, 8'h30);
        @(posedge clk);
        rail_a_enable <= 1'b1;
        wait_st(1'b0, 1'b0, 7'h01, 10);
        chk_span(n, 1, 3);
        chk({1'b0, rail_a_status.vcode}, 8'h50);
        @(posedge clk);
        rail_a_setting_select <= 1'b1;
        // Falling code 111 only skips the power-down ramp; a lower setting still ramps
        // at the fastest rate, 32 steps from 0x50 down to 0x30
        wait_st(1'b0, 1'b1, 7'h30, 2000);
        chk_span(n, 32 * step_tab[6], 32 * step_tab[6] + 4);
        @(posedge clk);
        rail_a_enable <= 1'b0;
        wait_st(1'b0, 1'b0, 7'h00, 10);
        chk_span(n, 1, 3);
        chk({1'b0, rail_a_status.vcode}, 8'h00);
        $display("start and stop test done");
        // Operating mode from the mode field or from the setting in use
        wr(BKRC_A_SET1_ADDR, 8'h20);
        wr(BKRC_A_SET2_ADDR, 8'hA0);
        @(posedge clk);
        rail_a_enable <= 1'b1;
        foreach (mrows[i]) begin
            wr(BKRC_A_CONF_ADDR, {6'h3F, mrows[i].m});
            rail_a_setting_select <= mrows[i].sel;
            repeat (3) @(posedge clk);
            #1;
            chk(8'(rail_a_status.mode), 8'(mrows[i].e));
        end
        $display("mode test done");
        // Phase counts and shedding on both rails
        wr(BKRC_B_CONF_ADDR, 8'hFC);
        @(posedge clk);
        rail_b_enable <= 1'b1;
        wait_st(1'b1, 1'b1, 7'h10, 10);
        chk(8'(rail_b_status.mode), 8'(BKRC_AUTO));
        foreach (prows[i]) begin
            wr(BKRC_PHASE_ADDR, prows[i].v);
            repeat (3) @(posedge clk);
            #1;
            chk({5'h00, rail_a_status.phases}, {5'h00, prows[i].pa});
            chk({7'h00, rail_a_status.shed}, {7'h00, prows[i].sa});
            chk({5'h00, rail_b_status.phases}, {5'h00, prows[i].pb});
            chk({7'h00, rail_b_status.shed}, {7'h00, prows[i].sb});
        end
        $display("phase test done");
        // Ceiling is writable only in test mode, and reloads at the next reset
        @(posedge clk);
        test_mode <= 1'b1;
        wr(BKRC_A_CEIL_ADDR, 8'hFF);
        rd_chk(BKRC_A_CEIL_ADDR, 8'h7F);
        test_mode <= 1'b0;
        do_reset();
        rd_chk(BKRC_A_CEIL_ADDR, 8'h50);
        rd_chk(BKRC_A_CONF_ADDR, 8'h90);
        $display("ceiling and second reset test done");
        complete_run();
    end
endmodule
